// ===== hdl/fbp_axil_slave.sv
// AXI4-Lite slave: address and data in either order, one of each held.
// Assumes the owner decodes the index and answers hit and data at once.
`timescale 1ns/1ps
`default_nettype none
module fbp_axil_slave (
    input  wire logic                        core_clk,
    input  wire logic                        rstN,
    input  wire logic [fbp_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [fbp_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [fbp_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [fbp_pkg::DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    output fbp_pkg::fbp_regwr_t              regWr,
    input  wire logic                        wrHit,
    output logic [fbp_pkg::IDX_W-1:0]        rdIdx,
    input  wire logic [7:0]                  rdData,
    input  wire logic                        rdHit
);
    typedef struct packed {
        logic                         awHeld;
        logic [fbp_pkg::IDX_W-1:0]    awIdx;
        logic                         awAligned;
        logic                         wHeld;
        logic [7:0]                   wData;
        logic                         wStrb0;
        logic                         bValid;
        logic [1:0]                   bResp;
        logic                         rValid;
        logic [fbp_pkg::DATA_W-1:0]   rData;
        logic [1:0]                   rResp;
    } fbp_axil_state_t;

    fbp_axil_state_t state;
    fbp_axil_state_t next_state;
    logic            commit;
    logic            rdAligned;

    assign commit    = state.awHeld && state.wHeld && !state.bValid;
    assign rdIdx     = s_axi_araddr[fbp_pkg::ADDR_W-1:2];
    assign rdAligned = (s_axi_araddr[1:0] == 2'b00);

    always_comb begin
        next_state = state;
        if (s_axi_awvalid && !state.awHeld) begin
            next_state.awHeld    = 1'b1;
            next_state.awIdx     = s_axi_awaddr[fbp_pkg::ADDR_W-1:2];
            next_state.awAligned = (s_axi_awaddr[1:0] == 2'b00);
        end
        if (s_axi_wvalid && !state.wHeld) begin
            next_state.wHeld  = 1'b1;
            next_state.wData  = s_axi_wdata[7:0];
            next_state.wStrb0 = s_axi_wstrb[0];
        end
        if (state.bValid && s_axi_bready) begin
            next_state.bValid = 1'b0;
        end
        // Response only after both halves are in; unaligned or unmapped gives a decode error
        if (commit) begin
            next_state.awHeld = 1'b0;
            next_state.wHeld  = 1'b0;
            next_state.bValid = 1'b1;
            next_state.bResp  = (state.awAligned && wrHit) ? fbp_pkg::RESP_OKAY
                                                           : fbp_pkg::RESP_DECERR;
        end
        if (state.rValid && s_axi_rready) begin
            next_state.rValid = 1'b0;
        end
        if (s_axi_arvalid && !state.rValid) begin
            next_state.rValid = 1'b1;
            next_state.rData  = '0;
            next_state.rResp  = fbp_pkg::RESP_DECERR;
            if (rdAligned && rdHit) begin
                next_state.rData = {24'h000000, rdData};
                next_state.rResp = fbp_pkg::RESP_OKAY;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready = !state.awHeld;
    assign s_axi_wready  = !state.wHeld;
    assign s_axi_bvalid  = state.bValid;
    assign s_axi_bresp   = state.bResp;
    assign s_axi_arready = !state.rValid;
    assign s_axi_rvalid  = state.rValid;
    assign s_axi_rdata   = state.rData;
    assign s_axi_rresp   = state.rResp;
    assign regWr.en      = commit && state.awAligned;
    assign regWr.idx     = state.awIdx;
    assign regWr.data    = state.wData;
    assign regWr.strb0   = state.wStrb0;
endmodule
`default_nettype wire

// ===== hdl/fbp_pkg.sv
// Constants and carrier types for the port block.
// Assumes a 32-bit AXI4-Lite bus; byte address is four times the index.
package fbp_pkg;
    localparam int          ADDR_W        = 18;
    localparam int          IDX_W         = 16;
    localparam int          DATA_W        = 32;
    localparam int          BIDIR_W       = 4;
    localparam int          INPUT_W       = 8;
    // Register indices
    localparam logic [15:0] IDX_IN_LEVELS = 16'hffde;
    localparam logic [15:0] IDX_IO_LATCH  = 16'hffdd;
    localparam logic [15:0] IDX_IO_DIR    = 16'hffed;
    localparam logic [15:0] IDX_DISP_CTRL = 16'hffe0;
    localparam logic [15:0] IDX_CONV_MODE = 16'hffe1;
    localparam logic [15:0] IDX_PWR_MODE  = 16'hffe2;
    // Reset values and fixed read bits
    localparam logic [7:0]  RST_IO_LATCH  = 8'hf0;
    localparam logic [7:0]  RST_IO_DIR    = 8'hf0;
    localparam logic [3:0]  UNUSED_HIGH   = 4'hf;
    localparam logic [7:0]  DIR_READBACK  = 8'hff;
    localparam logic [3:0]  SEG_GPIO      = 4'h0;
    // Converter channel codes that land on the input-only pins
    localparam logic [3:0]  CH_PIN_BASE   = 4'h4;
    // Field positions
    localparam int          SEG_LSB       = 0;
    localparam int          CH_LSB        = 0;
    localparam int          PWR_LSB       = 0;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_DECERR   = 2'b11;

    typedef enum logic [2:0] {
        FBP_ACTIVE,
        FBP_SUBACTIVE,
        FBP_SLEEP,
        FBP_SUBSLEEP,
        FBP_WATCH,
        FBP_STANDBY
    } fbp_pwr_t;

    typedef struct packed {
        logic             en;
        logic [IDX_W-1:0] idx;
        logic [7:0]       data;
        logic             strb0;
    } fbp_regwr_t;
endpackage

// ===== hdl/fbp_port_top.sv
// Four-bit I/O port and eight-bit input port behind AXI4-Lite registers.
// Assumes asynchronous pins and a common-output drive from core_clk logic.
//
// Behaviour
// R01: Four pins, each input or output
// R02: Output-direction bits read back latch value
// R03: Input-direction bits read back pin level
// R04: Data latch resets to f0, upper ones
// R05: Direction one drives latch, zero inputs
// R06: Settings apply only in general-purpose mode
// R07: Direction resets to f0, all inputs
// R08: Direction register is write-only, reads ones
// R09: Hi-Z reset/standby, hold sleep/watch, else normal
// R10: Eight input-only pins, read-only levels register
// R11: Input port read returns pin levels
// R12: Converter-selected input pin reads zero
// R13: Nonzero segment select drives common outputs
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module fbp_port_top (
    input  wire logic                              core_clk,
    input  wire logic                              rst_n,
    input  wire logic [fbp_pkg::ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic [2:0]                        s_axi_awprot,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [fbp_pkg::DATA_W-1:0]        s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [fbp_pkg::ADDR_W-1:0]        s_axi_araddr,
    input  wire logic [2:0]                        s_axi_arprot,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [fbp_pkg::DATA_W-1:0]             s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    input  wire logic [fbp_pkg::BIDIR_W-1:0]       bidirPinsIn,
    output logic      [fbp_pkg::BIDIR_W-1:0]       bidirPinsOut,
    output logic      [fbp_pkg::BIDIR_W-1:0]       bidirPinsOe,
    input  wire logic [fbp_pkg::INPUT_W-1:0]       inputOnlyPins,
    input  wire logic [fbp_pkg::BIDIR_W-1:0]       displayCommonDrive
);
    typedef struct packed {
        logic [fbp_pkg::BIDIR_W-1:0]  latch;
        logic [fbp_pkg::BIDIR_W-1:0]  direction;
        logic [3:0]                   segmentSelect;
        logic [3:0]                   channelSelect;
        fbp_pkg::fbp_pwr_t            powerMode;
        logic [fbp_pkg::BIDIR_W-1:0]  pinOut;
        logic [fbp_pkg::BIDIR_W-1:0]  pinOe;
    } fbp_top_state_t;

    fbp_top_state_t                      state;
    fbp_top_state_t                      next_state;
    logic                                coreRstN;
    logic [fbp_pkg::BIDIR_W-1:0]         bidirLevel;
    logic [fbp_pkg::INPUT_W-1:0]         inputLevel;
    logic [fbp_pkg::INPUT_W-1:0]         channelMask;
    logic [fbp_pkg::INPUT_W-1:0]         inputReadback;
    logic [fbp_pkg::BIDIR_W-1:0]         latchReadback;
    fbp_pkg::fbp_regwr_t                 regWr;
    logic                                wrHit;
    logic [fbp_pkg::IDX_W-1:0]           rdIdx;
    logic [7:0]                          rdData;
    logic                                rdHit;
    logic [3:0]                          channelOffset;
    logic                                writeApplies;

    // Reset release through two flops; assert is still immediate
    fbp_sync #(
        .WIDTH (1)
    ) u_reset_sync (
        .core_clk (core_clk),
        .rstN     (rst_n),
        .d        (1'b1),
        .q        (coreRstN)
    );

    // Pins are asynchronous to core_clk
    fbp_sync #(
        .WIDTH (fbp_pkg::BIDIR_W + fbp_pkg::INPUT_W)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rstN     (coreRstN),
        .d        ({bidirPinsIn, inputOnlyPins}),
        .q        ({bidirLevel, inputLevel})
    );

    fbp_axil_slave u_bus (
        .core_clk      (core_clk),
        .rstN          (coreRstN),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regWr         (regWr),
        .wrHit         (wrHit),
        .rdIdx         (rdIdx),
        .rdData        (rdData),
        .rdHit         (rdHit)
    );

    // R12: converter channel mask
    always_comb begin
        channelMask   = '0;
        channelOffset = state.channelSelect - fbp_pkg::CH_PIN_BASE;
        if (state.channelSelect >= fbp_pkg::CH_PIN_BASE &&
            channelOffset < 4'(fbp_pkg::INPUT_W)) begin
            channelMask[channelOffset[2:0]] = 1'b1;
        end
    end

    // R10: levels register
    // R11: live pin levels
    assign inputReadback = inputLevel & ~channelMask;

    // R02: output bits from latch
    // R03: input bits from pin
    assign latchReadback = (state.direction & state.latch) |
                           (~state.direction & bidirLevel);

    // Every mapped index answers; the levels register ignores writes
    always_comb begin
        wrHit = 1'b0;
        unique case (regWr.idx)
            fbp_pkg::IDX_IN_LEVELS,
            fbp_pkg::IDX_IO_LATCH,
            fbp_pkg::IDX_IO_DIR,
            fbp_pkg::IDX_DISP_CTRL,
            fbp_pkg::IDX_CONV_MODE,
            fbp_pkg::IDX_PWR_MODE: begin
                wrHit = 1'b1;
            end
            default: begin
                wrHit = 1'b0;
            end
        endcase
    end

    always_comb begin
        rdHit  = 1'b1;
        rdData = '0;
        unique case (rdIdx)
            fbp_pkg::IDX_IN_LEVELS: begin
                rdData = inputReadback;
            end
            // R04: unused bits read one
            fbp_pkg::IDX_IO_LATCH: begin
                rdData = {fbp_pkg::UNUSED_HIGH, latchReadback};
            end
            // R08: write-only, reads ones
            fbp_pkg::IDX_IO_DIR: begin
                rdData = fbp_pkg::DIR_READBACK;
            end
            fbp_pkg::IDX_DISP_CTRL: begin
                rdData = {4'h0, state.segmentSelect};
            end
            fbp_pkg::IDX_CONV_MODE: begin
                rdData = {4'h0, state.channelSelect};
            end
            fbp_pkg::IDX_PWR_MODE: begin
                rdData = {5'h00, state.powerMode};
            end
            default: begin
                rdHit  = 1'b0;
            end
        endcase
    end

    assign writeApplies = regWr.en && regWr.strb0;

    always_comb begin
        next_state = state;
        if (writeApplies) begin
            unique case (regWr.idx)
                fbp_pkg::IDX_IO_LATCH: begin
                    next_state.latch = regWr.data[fbp_pkg::BIDIR_W-1:0];
                end
                fbp_pkg::IDX_IO_DIR: begin
                    next_state.direction = regWr.data[fbp_pkg::BIDIR_W-1:0];
                end
                fbp_pkg::IDX_DISP_CTRL: begin
                    next_state.segmentSelect = regWr.data[fbp_pkg::SEG_LSB +: 4];
                end
                fbp_pkg::IDX_CONV_MODE: begin
                    next_state.channelSelect = regWr.data[fbp_pkg::CH_LSB +: 4];
                end
                fbp_pkg::IDX_PWR_MODE: begin
                    next_state.powerMode = fbp_pkg::fbp_pwr_t'(regWr.data[fbp_pkg::PWR_LSB +: 3]);
                end
                default: begin
                    next_state.latch = state.latch;
                end
            endcase
        end

        // R09: pin state per mode
        unique case (state.powerMode)
            fbp_pkg::FBP_ACTIVE,
            fbp_pkg::FBP_SUBACTIVE: begin
                // R13: common outputs override
                if (state.segmentSelect != fbp_pkg::SEG_GPIO) begin
                    next_state.pinOut = displayCommonDrive;
                    next_state.pinOe  = '1;
                end else begin
                    // R05: direction drives latch
                    // R06: only in general-purpose mode
                    // R01: per-pin input or output
                    next_state.pinOut = state.latch;
                    next_state.pinOe  = state.direction;
                end
            end
            // Frozen pins keep whatever was last driven, even a common output
            fbp_pkg::FBP_SLEEP,
            fbp_pkg::FBP_SUBSLEEP,
            fbp_pkg::FBP_WATCH: begin
                next_state.pinOut = state.pinOut;
                next_state.pinOe  = state.pinOe;
            end
            fbp_pkg::FBP_STANDBY: begin
                next_state.pinOut = '0;
                next_state.pinOe  = '0;
            end
            // Unused mode codes behave as standby, the safe choice for the board
            default: begin
                next_state.pinOut = '0;
                next_state.pinOe  = '0;
            end
        endcase
    end

    // R04: latch resets to f0
    // R07: direction resets to inputs
    always_ff @(posedge core_clk or negedge coreRstN) begin
        if (!coreRstN) begin
            state.latch         <= fbp_pkg::RST_IO_LATCH[fbp_pkg::BIDIR_W-1:0];
            state.direction     <= fbp_pkg::RST_IO_DIR[fbp_pkg::BIDIR_W-1:0];
            state.segmentSelect <= fbp_pkg::SEG_GPIO;
            state.channelSelect <= 4'h0;
            state.powerMode     <= fbp_pkg::FBP_ACTIVE;
            state.pinOut        <= '0;
            state.pinOe         <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign bidirPinsOut = state.pinOut;
    assign bidirPinsOe  = state.pinOe;
endmodule
`default_nettype wire

// ===== hdl/fbp_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes nothing reads stage one; the caller takes only q.
`timescale 1ns/1ps
`default_nettype none
module fbp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rstN,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } fbp_sync_state_t;

    fbp_sync_state_t state;
    fbp_sync_state_t next_state;

    always_comb begin
        next_state.stage1 = d;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign q = state.stage2;
endmodule
`default_nettype wire

// ===== tb/fbp_board_model.sv
// Board side of the four pins: a weak drive that yields to the block.
// Assumes the bench sets the weak level; X floats to the inverse.
`timescale 1ns/1ps
`default_nettype none
module fbp_board_model (
    input  wire logic       core_clk,
    input  wire logic [3:0] devOut,
    input  wire logic [3:0] devOe,
    input  wire logic [3:0] weakDrive,
    output logic      [3:0] pinLevel
);
    logic [3:0] lastLevel = 4'h0;
    always_ff @(posedge core_clk) begin
        lastLevel <= pinLevel;
    end
    // Undriven lines must not look stable, hence the inverse of the last level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pinLevel[i] = (weakDrive[i] === 1'hx) ? ~lastLevel[i] : weakDrive[i];
            pinLevel[i] = devOe[i] ? devOut[i] : pinLevel[i];
        end
    end
endmodule
`default_nettype wire

// ===== tb/fbp_port_monitor.sv
// Checker for the port block: bus handshakes, fixed read bits and pin release.
// Assumes it is bound to fbp_port_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fbp_port_monitor (
    input wire logic                         core_clk,
    input wire logic                         rst_n,
    input wire logic [fbp_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input wire logic                         s_axi_awvalid,
    input wire logic                         s_axi_awready,
    input wire logic                         s_axi_wvalid,
    input wire logic                         s_axi_wready,
    input wire logic [1:0]                   s_axi_bresp,
    input wire logic                         s_axi_bvalid,
    input wire logic                         s_axi_bready,
    input wire logic [fbp_pkg::ADDR_W-1:0]   s_axi_araddr,
    input wire logic                         s_axi_arvalid,
    input wire logic                         s_axi_arready,
    input wire logic [fbp_pkg::DATA_W-1:0]   s_axi_rdata,
    input wire logic [1:0]                   s_axi_rresp,
    input wire logic                         s_axi_rvalid,
    input wire logic                         s_axi_rready,
    input wire logic [fbp_pkg::BIDIR_W-1:0]  bidirPinsOe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic bothIn;
    logic arIn;
    assign bothIn = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign arIn = s_axi_arvalid && s_axi_arready;

    property p_wrResp; bothIn |-> ##2 s_axi_bvalid; endproperty
    a_wrResp: assert property (p_wrResp) else $error("write response late");
    property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bHold: assert property (p_bHold) else $error("write response dropped");
    property p_rdResp; arIn |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0; endproperty
    a_rdResp: assert property (p_rdResp) else $error("read answer wrong");
    property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rHold: assert property (p_rHold) else $error("read data dropped");
    property p_dirOnes;
        arIn && s_axi_araddr == {fbp_pkg::IDX_IO_DIR, 2'h0} |=> s_axi_rdata == 32'hff;
    endproperty
    a_dirOnes: assert property (p_dirOnes) else $error("direction read not ones");
    property p_latchUpper;
        arIn && s_axi_araddr == {fbp_pkg::IDX_IO_LATCH, 2'h0} |=> s_axi_rdata[7:4] == 4'hf;
    endproperty
    a_latchUpper: assert property (p_latchUpper) else $error("latch upper bits");
    property p_lvlWr;
        bothIn && s_axi_awaddr == {fbp_pkg::IDX_IN_LEVELS, 2'h0}
            |-> ##2 s_axi_bresp == fbp_pkg::RESP_OKAY;
    endproperty
    a_lvlWr: assert property (p_lvlWr) else $error("levels write refused");
    // Internal reset lags two edges, so pins must stay released across them
    property p_resetHiZ; $rose(rst_n) |-> bidirPinsOe == 4'h0 ##1 bidirPinsOe == 4'h0;
    endproperty
    a_resetHiZ: assert property (p_resetHiZ) else $error("pins driven in reset");
    c_wr: cover property (bothIn);
    c_rd: cover property (arIn);
    c_drive: cover property (bidirPinsOe == 4'hf);
endmodule
bind fbp_port_top fbp_port_monitor fbp_port_monitor_i (.*);
`default_nettype wire

// ===== tb/test_four_bit_io_and_input_port.sv
// Self-checking bench for the port block, with a board model on the pins.
// Assumes byte address is four times the register index.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module test_four_bit_io_and_input_port;
    logic        core_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0, bidirPinsIn, bidirPinsOut, bidirPinsOe;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [7:0]  inputOnlyPins = 8'h0;
    logic [3:0]  displayCommonDrive = 4'h0, weakDrive = 4'h0;
    int          errorCnt = 0, compares = 0;

    fbp_port_top fbp_port_top_i (.*);
    fbp_board_model fbp_board_model_i (.core_clk, .devOut(bidirPinsOut), .devOe(bidirPinsOe),
        .weakDrive, .pinLevel(bidirPinsIn));

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    function automatic logic [17:0] ad(input logic [15:0] i);
        return {i, 2'h0};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            errorCnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        bit aw = 0, w = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 1'h0;
            end
        end while (!(aw && w));
        do @(posedge core_clk); while (s_axi_bvalid !== 1'h1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [17:0] a, output logic [31:0] d);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge core_clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic tReset;
        logic [31:0] d;
        rd(ad(fbp_pkg::IDX_IO_LATCH), d);
        `CHK(d, 32'hf0);
        rd(ad(fbp_pkg::IDX_IO_DIR), d);
        `CHK(d, 32'hff);
        `CHK(bidirPinsOe, 4'h0);
        $display("test reset done");
    endtask

    task automatic tDir;
        logic [31:0] d;
        weakDrive <= 4'h5;
        wr(ad(fbp_pkg::IDX_IO_LATCH), 8'h0a);
        wr(ad(fbp_pkg::IDX_IO_DIR), 8'h03);
        settle(3);
        `CHK(bidirPinsOe, 4'h3);
        `CHK(bidirPinsOut, 4'ha);
        rd(ad(fbp_pkg::IDX_IO_LATCH), d);
        `CHK(d, 32'hf6);
        weakDrive <= 4'ha;
        settle(3);
        rd(ad(fbp_pkg::IDX_IO_LATCH), d);
        `CHK(d, 32'hfa);
        rd(ad(fbp_pkg::IDX_IO_DIR), d);
        `CHK(d, 32'hff);
        $display("test direction done");
    endtask

    task automatic tSeg;
        logic [31:0] d;
        displayCommonDrive <= 4'h9;
        wr(ad(fbp_pkg::IDX_DISP_CTRL), 8'h08);
        settle(2);
        `CHK(bidirPinsOe, 4'hf);
        `CHK(bidirPinsOut, 4'h9);
        rd(ad(fbp_pkg::IDX_IO_LATCH), d);
        `CHK(d, 32'hfa);
        wr(ad(fbp_pkg::IDX_DISP_CTRL), 8'h00);
        settle(2);
        `CHK(bidirPinsOe, 4'h3);
        `CHK(bidirPinsOut, 4'ha);
        $display("test segment done");
    endtask

    task automatic tPower;
        logic [3:0] eOe;
        logic [3:0] eOut;
        logic [3:0] v;
        eOe = 4'h3;
        for (int m = 0; m < 6; m++) begin
            v = 4'(m * 3 + 1);
            wr(ad(fbp_pkg::IDX_PWR_MODE), 8'(m));
            wr(ad(fbp_pkg::IDX_IO_LATCH), {4'h0, v});
            settle(2);
            if (m < 2) begin
                eOut = v;
            end else if (m == 5) begin
                eOe = 4'h0;
                eOut = 4'h0;
            end
            `CHK(bidirPinsOe, eOe);
            `CHK(bidirPinsOut, eOut);
        end
        wr(ad(fbp_pkg::IDX_PWR_MODE), 8'h00);
        settle(2);
        `CHK(bidirPinsOe, 4'h3);
        $display("test power done");
    endtask

    task automatic tInput;
        logic [31:0] d;
        @(posedge core_clk);
        inputOnlyPins <= 8'ha5;
        settle(3);
        rd(ad(fbp_pkg::IDX_IN_LEVELS), d);
        `CHK(d, 32'ha5);
        wr(ad(fbp_pkg::IDX_IN_LEVELS), 8'h00);
        `CHK(resp, fbp_pkg::RESP_OKAY);
        rd(ad(fbp_pkg::IDX_IN_LEVELS), d);
        `CHK(d, 32'ha5);
        inputOnlyPins <= 8'hff;
        for (int c = 0; c < 16; c++) begin
            wr(ad(fbp_pkg::IDX_CONV_MODE), 8'(c));
            rd(ad(fbp_pkg::IDX_IN_LEVELS), d);
            `CHK(d, (c >= 4 && c <= 11) ? 32'(8'hff & ~(8'h1 << (c - 4))) : 32'hff);
        end
        rd(18'h00002, d);
        `CHK({d[29:0], resp}, {30'h0, fbp_pkg::RESP_DECERR});
        $display("test input port done");
    endtask

    task automatic reportAndStop;
        $display("compares=%0d errors=%0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge core_clk);
        tReset();
        tDir();
        tSeg();
        tPower();
        tInput();
        reportAndStop();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        errorCnt++;
        reportAndStop();
    end
endmodule
`default_nettype wire
